// [eer_pkg.sv]
// Notes on behaviour
// - reads behave identically whatever protection is set
// - counter advances by one after each array byte read
// - master nack in ninth slot ends read, standby
// - random read: dummy write, repeated start, read select
// - random read: device sends byte, master nacks, stops
// - current read: select only, byte at counter, increment
// - acked byte makes device send the next byte
// - counter wraps from last location to zero
// - address top bit set selects protect register
// - register reads upper nibble zero, lower stored fields
// - further register bytes repeat the same value
// - no register delivery during programming cycle
// - delivered state: array all ones, register zero
// - ack only matching select, else release and standby
// - write select then two acked address bytes, high first
// - programming cycle: data released, all requests ignored
// - register: enable, two size bits, lock bit
package eer_pkg;
	// array and select
	localparam int EER_MEM_AW = 14;
	// arbitrary value, no meaning beyond this model
	localparam logic [6:0] EER_DEV_SELECT = 7'h3A;
	localparam logic [7:0] EER_ERASED = 8'hFF;
	localparam logic [3:0] EER_WP_RESET = 4'h0;
	localparam logic [3:0] EER_WP_PAD = 4'h0;
	localparam int EER_REG_FLAG_BIT = 7;
	localparam int EER_WP_LOCK_BIT = 0;
	// controller register map
	localparam logic [7:0] EER_OFS_CTRL = 8'h00;
	localparam logic [7:0] EER_OFS_ADDR = 8'h04;
	localparam logic [7:0] EER_OFS_STATUS = 8'h08;
	localparam logic [7:0] EER_OFS_DATA = 8'h0C;
	localparam int EER_CTRL_START_BIT = 0;
	localparam int EER_CTRL_CUR_BIT = 1;
	localparam int EER_CTRL_CNT_LSB = 8;
	localparam logic [1:0] EER_RESP_OKAY = 2'h0;
	localparam logic [1:0] EER_RESP_SLVERR = 2'h2;
	// serial clock timing
	localparam int EER_SYS_CLK_KHZ = 50000;
	localparam int EER_SCL_KHZ = 400;
	localparam int EER_QUARTER_CYCLES = (EER_SYS_CLK_KHZ + 4 * EER_SCL_KHZ - 1) / (4 * EER_SCL_KHZ);
endpackage : eer_pkg

// [eer_link_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface eer_link_if;
	logic scl;
	logic hostSdaOut;
	logic hostSdaOe;
	logic devSdaOut;
	logic devSdaOe;
	logic sda;
	// open-drain wired-and with pull-up
	assign sda = !((hostSdaOe && !hostSdaOut) || (devSdaOe && !devSdaOut));
	modport host (output scl, output hostSdaOut, output hostSdaOe, input sda);
	modport dev (input scl, input sda, output devSdaOut, output devSdaOe);
endinterface : eer_link_if
`default_nettype wire

// [eer_device.sv]
`timescale 1ns/10ps
`default_nettype none
module eer_device #(
	parameter int ADDR_W = eer_pkg::EER_MEM_AW,
	parameter logic [6:0] SELECT = eer_pkg::EER_DEV_SELECT
) (
	// link
	input wire logic linkClk,
	input wire logic reset_n,
	eer_link_if.dev link,
	// neighbouring write path
	input wire logic progBusy,
	input wire logic memWrEn,
	input wire logic [ADDR_W-1:0] memWrAddr,
	input wire logic [7:0] memWrData,
	input wire logic wpWrEn,
	input wire logic [3:0] wpWrData,
	// status
	output logic ready,
	output logic [ADDR_W-1:0] curAddr,
	output logic [3:0] wpCfg
);
	import eer_pkg::*;

	typedef enum logic [2:0] {
		D_INIT,
		D_IDLE,
		D_RECV,
		D_ACKOUT,
		D_SEND,
		D_ACKIN
	} eer_dstate_t;

	typedef enum logic [1:0] {
		P_SEL,
		P_AHI,
		P_ALO,
		P_DATA
	} eer_phase_t;

	typedef struct packed {
		eer_dstate_t state;
		eer_phase_t ph;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] hi;
		logic [ADDR_W-1:0] addr;
		logic regSel;
		logic rw;
		logic ackSeen;
		logic sdaLow;
		logic [2:0] scl;
		logic [2:0] sda;
		logic [3:0] wp;
		logic [ADDR_W-1:0] sweep;
		logic ready;
	} eer_dev_t;

	////////////////////////////////////////////////////////////////////////
	logic [7:0] mem [0:(1 << ADDR_W) - 1];
	eer_dev_t r;
	eer_dev_t next_r;
	logic rise;
	logic fall;
	logic start;
	logic stop;
	logic [7:0] rdByte;

	// index 1 is the synchronised level, index 2 the previous one
	assign rise = r.scl[1] && !r.scl[2];
	assign fall = !r.scl[1] && r.scl[2];
	assign start = r.scl[1] && r.scl[2] && r.sda[2] && !r.sda[1];
	assign stop = r.scl[1] && r.scl[2] && !r.sda[2] && r.sda[1];

	// protection state never gates this path
	assign rdByte = r.regSel ? {EER_WP_PAD, r.wp} : mem[r.addr];

	////////////////////////////////////////////////////////////////////////
	// array store; the sweep after reset erases every byte
	always_ff @(posedge linkClk) begin
		if (r.state == D_INIT) begin
			mem[r.sweep] <= EER_ERASED;
		end else if (memWrEn) begin
			mem[memWrAddr] <= memWrData;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_r = r;
		next_r.scl = {r.scl[1:0], link.scl};
		next_r.sda = {r.sda[1:0], link.sda};
		if (wpWrEn && !r.wp[EER_WP_LOCK_BIT]) begin
			next_r.wp = wpWrData;
		end
		case (r.state)
			D_INIT: begin
				next_r.sweep = r.sweep + 1'b1;
				if (&r.sweep) begin
					next_r.state = D_IDLE;
				end
			end
			D_IDLE: begin
				next_r.sdaLow = 1'b0;
			end
			D_RECV: begin
				if (rise && r.cnt < 4'h8) begin
					next_r.sh = {r.sh[6:0], r.sda[1]};
					next_r.cnt = r.cnt + 4'h1;
				end else if (fall && r.cnt == 4'h8) begin
					next_r.cnt = 4'h0;
					next_r.state = D_ACKOUT;
					next_r.sdaLow = 1'b1;
					case (r.ph)
						P_SEL: begin
							if (r.sh[7:1] == SELECT) begin
								next_r.rw = r.sh[0];
							end else begin
								next_r.state = D_IDLE;
								next_r.sdaLow = 1'b0;
							end
						end
						P_AHI: begin
							next_r.regSel = r.sh[EER_REG_FLAG_BIT];
							next_r.hi = r.sh;
						end
						P_ALO: begin
							if (!r.regSel) begin
								// top address bits beyond the array are dropped
								next_r.addr = ADDR_W'({r.hi, r.sh});
							end
						end
						default: begin
							// data bytes belong to the write path
							next_r.state = D_IDLE;
							next_r.sdaLow = 1'b0;
						end
					endcase
				end
			end
			D_ACKOUT: begin
				if (fall) begin
					next_r.sdaLow = 1'b0;
					next_r.state = D_RECV;
					case (r.ph)
						P_SEL: begin
							if (r.rw) begin
								next_r.sh = rdByte;
								next_r.sdaLow = !rdByte[7];
								next_r.state = D_SEND;
							end else begin
								next_r.ph = P_AHI;
							end
						end
						P_AHI: begin
							next_r.ph = P_ALO;
						end
						P_ALO: begin
							next_r.ph = P_DATA;
						end
						default: begin
							next_r.state = D_IDLE;
						end
					endcase
				end
			end
			D_SEND: begin
				if (fall) begin
					if (r.cnt == 4'h7) begin
						next_r.cnt = 4'h0;
						next_r.sdaLow = 1'b0;
						next_r.ackSeen = 1'b0;
						next_r.state = D_ACKIN;
						if (!r.regSel) begin
							// natural binary wrap past the top location
							next_r.addr = r.addr + 1'b1;
						end
					end else begin
						next_r.cnt = r.cnt + 4'h1;
						next_r.sh = {r.sh[6:0], 1'b0};
						next_r.sdaLow = !r.sh[6];
					end
				end
			end
			D_ACKIN: begin
				if (rise) begin
					next_r.ackSeen = !r.sda[1];
				end else if (fall) begin
					if (r.ackSeen) begin
						next_r.sh = rdByte;
						next_r.sdaLow = !rdByte[7];
						next_r.state = D_SEND;
					end else begin
						next_r.state = D_IDLE;
					end
				end
			end
			default: begin
				next_r.state = D_IDLE;
			end
		endcase
		// bus conditions override the byte engine
		if (r.state != D_INIT) begin
			if (progBusy) begin
				next_r.state = D_IDLE;
				next_r.sdaLow = 1'b0;
			end else if (start) begin
				next_r.state = D_RECV;
				next_r.ph = P_SEL;
				next_r.cnt = 4'h0;
				next_r.sdaLow = 1'b0;
			end else if (stop) begin
				// a later current read goes back to the array
				next_r.state = D_IDLE;
				next_r.sdaLow = 1'b0;
				next_r.regSel = 1'b0;
			end
		end
		next_r.ready = next_r.state != D_INIT;
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge linkClk or negedge reset_n) begin
		if (!reset_n) begin
			r <= '0;
			r.wp <= EER_WP_RESET;
		end else begin
			r <= next_r;
		end
	end

	assign link.devSdaOe = r.sdaLow;
	assign link.devSdaOut = 1'b0;
	assign ready = r.ready;
	assign curAddr = r.addr;
	assign wpCfg = r.wp;
endmodule : eer_device
`default_nettype wire

// [eer_host.sv]
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module eer_host #(
	parameter int QUARTER = eer_pkg::EER_QUARTER_CYCLES,
	parameter logic [6:0] SELECT = eer_pkg::EER_DEV_SELECT
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// link
	eer_link_if.host link,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import eer_pkg::*;

	typedef enum logic [2:0] {H_IDLE, H_START, H_WRITE, H_READ, H_WAIT, H_STOP} eer_hstate_t;
	typedef enum logic [2:0] {S_SELW, S_AHI, S_ALO, S_SELR, S_DATA} eer_stage_t;
	typedef struct packed {
		eer_hstate_t hst;
		eer_stage_t stg;
		logic [1:0] q;
		logic [15:0] div;
		logic [3:0] bitCnt;
		logic [7:0] sh;
		logic [7:0] remain;
		logic ackOk;
		logic scl;
		logic sdaLow;
		logic [1:0] sdaIn;
		logic awHeld;
		logic [7:0] awAddr;
		logic wHeld;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic curMode;
		logic [7:0] count;
		logic [15:0] addr;
		logic busy;
		logic nack;
		logic dataValid;
		logic [7:0] data;
	} eer_host_t;

	eer_host_t r;
	eer_host_t next_r;
	logic tick;
	logic [31:0] wm;

	function automatic logic [31:0] eer_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction : eer_merge

	assign tick = r.div == 16'(QUARTER - 1);

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_r = r;
		wm = 32'h0;
		next_r.sdaIn = {r.sdaIn[0], link.sda};
		// register write channel
		if (r.bvalid && s_axi_bready) begin
			next_r.bvalid = 1'b0;
		end
		if (r.awready && s_axi_awvalid) begin
			next_r.awHeld = 1'b1;
			next_r.awAddr = s_axi_awaddr;
		end
		if (r.wready && s_axi_wvalid) begin
			next_r.wHeld = 1'b1;
			next_r.wData = s_axi_wdata;
			next_r.wStrb = s_axi_wstrb;
		end
		if (next_r.awHeld && next_r.wHeld) begin
			next_r.awHeld = 1'b0;
			next_r.wHeld = 1'b0;
			next_r.bvalid = 1'b1;
			next_r.bresp = EER_RESP_OKAY;
			case ({next_r.awAddr[7:2], 2'h0})
				EER_OFS_CTRL: begin
					wm = eer_merge({16'h0, r.count, 6'h0, r.curMode, 1'b0}, next_r.wData,
						next_r.wStrb);
					if (!r.busy) begin
						next_r.curMode = wm[EER_CTRL_CUR_BIT];
						next_r.count = wm[EER_CTRL_CNT_LSB +: 8];
						if (wm[EER_CTRL_START_BIT]) begin
							next_r.busy = 1'b1;
							next_r.nack = 1'b0;
							next_r.remain = wm[EER_CTRL_CNT_LSB +: 8];
							next_r.stg = wm[EER_CTRL_CUR_BIT] ? S_SELR : S_SELW;
							next_r.hst = H_START;
							next_r.q = 2'h0;
							next_r.div = 16'h0;
						end
					end
				end
				EER_OFS_ADDR: begin
					wm = eer_merge({16'h0, r.addr}, next_r.wData, next_r.wStrb);
					if (!r.busy) begin
						next_r.addr = wm[15:0];
					end
				end
				default: begin
					next_r.bresp = EER_RESP_SLVERR;
				end
			endcase
		end
		// register read channel
		if (r.rvalid && s_axi_rready) begin
			next_r.rvalid = 1'b0;
		end
		if (r.arready && s_axi_arvalid) begin
			next_r.rvalid = 1'b1;
			next_r.rresp = EER_RESP_OKAY;
			case ({s_axi_araddr[7:2], 2'h0})
				EER_OFS_CTRL: next_r.rdata = {16'h0, r.count, 6'h0, r.curMode, 1'b0};
				EER_OFS_ADDR: next_r.rdata = {16'h0, r.addr};
				EER_OFS_STATUS: next_r.rdata = {29'h0, r.dataValid, r.nack, r.busy};
				EER_OFS_DATA: begin
					next_r.rdata = {24'h0, r.data};
					next_r.dataValid = 1'b0;
				end
				default: begin
					next_r.rdata = 32'h0;
					next_r.rresp = EER_RESP_SLVERR;
				end
			endcase
		end
		////////////////////////////////////////////////////////////////////
		// serial engine; a new byte set after the clear above wins
		if (r.hst == H_IDLE || r.hst == H_WAIT) begin
			next_r.div = 16'h0;
		end else begin
			next_r.div = tick ? 16'h0 : r.div + 16'h1;
		end
		case (r.hst)
			H_IDLE: begin
			end
			H_START: begin
				if (tick && r.q == 2'h3) begin
					next_r.sh = {SELECT, r.stg == S_SELR};
					next_r.bitCnt = 4'h0;
					next_r.hst = H_WRITE;
				end
			end
			H_WRITE: begin
				if (tick && r.q == 2'h2 && r.bitCnt == 4'h8) begin
					next_r.ackOk = !r.sdaIn[1];
				end else if (tick && r.q == 2'h3) begin
					if (r.bitCnt < 4'h8) begin
						next_r.bitCnt = r.bitCnt + 4'h1;
						next_r.sh = {r.sh[6:0], 1'b0};
					end else if (!r.ackOk) begin
						next_r.nack = 1'b1;
						next_r.hst = H_STOP;
					end else begin
						next_r.bitCnt = 4'h0;
						case (r.stg)
							S_SELW: begin
								next_r.stg = S_AHI;
								next_r.sh = r.addr[15:8];
							end
							S_AHI: begin
								next_r.stg = S_ALO;
								next_r.sh = r.addr[7:0];
							end
							S_ALO: begin
								next_r.stg = S_SELR;
								next_r.hst = H_START;
							end
							default: begin
								next_r.stg = S_DATA;
								next_r.hst = H_READ;
							end
						endcase
					end
				end
			end
			H_READ: begin
				if (tick && r.q == 2'h2 && r.bitCnt < 4'h8) begin
					next_r.sh = {r.sh[6:0], r.sdaIn[1]};
				end else if (tick && r.q == 2'h3) begin
					if (r.bitCnt < 4'h7) begin
						next_r.bitCnt = r.bitCnt + 4'h1;
					end else if (r.bitCnt == 4'h7) begin
						next_r.bitCnt = 4'h8;
						if (next_r.dataValid) begin
							next_r.hst = H_WAIT;
						end else begin
							next_r.data = r.sh;
							next_r.dataValid = 1'b1;
						end
					end else if (r.remain == 8'h0) begin
						next_r.hst = H_STOP;
					end else begin
						next_r.remain = r.remain - 8'h1;
						next_r.bitCnt = 4'h0;
					end
				end
			end
			H_WAIT: begin
				if (!next_r.dataValid) begin
					next_r.data = r.sh;
					next_r.dataValid = 1'b1;
					next_r.hst = H_READ;
				end
			end
			H_STOP: begin
				if (tick && r.q == 2'h3) begin
					next_r.busy = 1'b0;
					next_r.hst = H_IDLE;
				end
			end
			default: begin
				next_r.hst = H_IDLE;
			end
		endcase
		if (tick && r.hst != H_IDLE && r.hst != H_WAIT) begin
			next_r.q = r.q + 2'h1;
		end
		// pin levels for the coming quarter
		case (next_r.hst)
			H_IDLE: next_r.scl = 1'b1;
			H_WAIT: next_r.scl = 1'b0;
			H_STOP: next_r.scl = next_r.q != 2'h0;
			default: next_r.scl = next_r.q == 2'h1 || next_r.q == 2'h2;
		endcase
		case (next_r.hst)
			H_START: next_r.sdaLow = next_r.q[1];
			H_WRITE: next_r.sdaLow = next_r.bitCnt < 4'h8 && !next_r.sh[7];
			H_READ: next_r.sdaLow = next_r.bitCnt == 4'h8 && next_r.remain != 8'h0;
			H_STOP: next_r.sdaLow = !next_r.q[1];
			default: next_r.sdaLow = 1'b0;
		endcase
		next_r.awready = !next_r.awHeld && !next_r.bvalid;
		next_r.wready = !next_r.wHeld && !next_r.bvalid;
		next_r.arready = !next_r.rvalid;
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			r <= '0;
			r.scl <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign link.scl = r.scl;
	assign link.hostSdaOe = r.sdaLow;
	assign link.hostSdaOut = 1'b0;
	assign s_axi_awready = r.awready;
	assign s_axi_wready = r.wready;
	assign s_axi_bresp = r.bresp;
	assign s_axi_bvalid = r.bvalid;
	assign s_axi_arready = r.arready;
	assign s_axi_rdata = r.rdata;
	assign s_axi_rresp = r.rresp;
	assign s_axi_rvalid = r.rvalid;
endmodule : eer_host
`default_nettype wire

// [eer_link_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module eer_link_assertions (
	// clocks and reset
	input wire logic sys_clk,
	input wire logic linkClk,
	input wire logic reset_n,
	// link
	input wire logic scl,
	input wire logic hostSdaOut,
	input wire logic hostSdaOe,
	input wire logic devSdaOut,
	input wire logic devSdaOe,
	input wire logic sda
);
	sequence s_start;
		scl && $fell(sda);
	endsequence
	sequence s_stop;
		scl && $rose(sda);
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	a_dev_drive_timing: assert property (@(posedge linkClk) disable iff (!reset_n)
		$rose(devSdaOe) |-> !scl) else $error("device pulls sda while scl high");
	a_dev_stable_high: assert property (@(posedge linkClk) disable iff (!reset_n)
		scl && $past(scl) |-> $stable(devSdaOe)) else $error("device sda moved, scl high");
	a_dev_stop_idle: assert property (@(posedge linkClk) disable iff (!reset_n)
		s_stop |-> !devSdaOe [*8]) else $error("device drives after stop");
	a_dev_start_quiet: assert property (@(posedge linkClk) disable iff (!reset_n)
		s_start |-> !devSdaOe [*8]) else $error("device drives during select");
	a_one_driver: assert property (@(posedge sys_clk) disable iff (!reset_n)
		scl && devSdaOe |-> !hostSdaOe) else $error("both ends drive sda");
	a_start_setup: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$rose(hostSdaOe) && scl |-> $past(scl, 8)) else $error("start setup too short");
	a_scl_high_min: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$rose(scl) |-> scl [*8]) else $error("scl high too short");
	a_scl_low_min: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$fell(scl) |-> !scl [*8]) else $error("scl low too short");
	a_start_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
		s_start |-> scl [*4]) else $error("start hold too short");
	a_stop_setup: assert property (@(posedge sys_clk) disable iff (!reset_n)
		s_stop |-> $past(scl, 4)) else $error("stop setup too short");
endmodule : eer_link_assertions
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import eer_pkg::*;
	localparam int AW = 6;
	logic sys_clk = 1'b0;
	logic linkClk = 1'b0;
	logic reset_n = 1'b0;
	logic progBusy = 1'b0;
	logic memWrEn = 1'b0;
	logic [AW-1:0] memWrAddr = '0;
	logic [7:0] memWrData = 8'h00;
	logic wpWrEn = 1'b0;
	logic [3:0] wpWrData = 4'h0;
	logic ready;
	logic [AW-1:0] curAddr;
	logic [3:0] wpCfg;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	int mismatches = 0;
	int checksDone = 0;
	always #10 sys_clk = ~sys_clk;
	always #7.5 linkClk = ~linkClk;
	////////////////////////////////////////////////////////////////////////////////
	eer_link_if link ();
	eer_host #(.QUARTER(8)) i_eer_host (.sys_clk, .reset_n, .link(link),
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	eer_device #(.ADDR_W(AW)) i_eer_device (.linkClk, .reset_n, .link(link), .progBusy,
		.memWrEn, .memWrAddr, .memWrData, .wpWrEn, .wpWrData, .ready, .curAddr, .wpCfg);
	eer_link_assertions i_eer_link_assertions (.sys_clk, .linkClk, .reset_n, .scl(link.scl),
		.hostSdaOut(link.hostSdaOut), .hostSdaOe(link.hostSdaOe),
		.devSdaOut(link.devSdaOut), .devSdaOe(link.devSdaOe), .sda(link.sda));
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] pat(input int a);
		return 8'(a) ^ 8'hA5;
	endfunction : pat
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checksDone++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checksDone, mismatches);
		if (mismatches == 0 && checksDone > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_of_test
	task automatic axiWr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axiWr
	task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axiRd
	task automatic memPut(input logic [AW-1:0] a, input logic [7:0] d);
		@(posedge linkClk);
		memWrEn <= 1'b1;
		memWrAddr <= a;
		memWrData <= d;
		@(posedge linkClk);
		memWrEn <= 1'b0;
	endtask : memPut
	task automatic wpPut(input logic [3:0] d);
		@(posedge linkClk);
		wpWrEn <= 1'b1;
		wpWrData <= d;
		@(posedge linkClk);
		wpWrEn <= 1'b0;
	endtask : wpPut
	task automatic waitIdle(output logic [31:0] s);
		logic [1:0] r;
		int k;
		k = 0;
		do begin
			axiRd(EER_OFS_STATUS, s, r);
			k++;
		end while (s[0] !== 1'b0 && k < 3000);
	endtask : waitIdle
	// one serial read, every byte fetched through the data register
	task automatic eeRead(input logic [15:0] a, input logic cur, input logic [7:0] e[$]);
		logic [31:0] v;
		logic [1:0] r;
		int k;
		if (!cur) axiWr(EER_OFS_ADDR, {16'h0, a}, r);
		axiWr(EER_OFS_CTRL, {16'h0, 8'(e.size() - 1), 6'h0, cur, 1'b1}, r);
		chk("ctrl bresp", EER_RESP_OKAY, r);
		foreach (e[i]) begin
			// leave the second byte unread so the host must stall the clock
			if (i == 1) repeat (600) @(posedge sys_clk);
			k = 0;
			do begin
				axiRd(EER_OFS_STATUS, v, r);
				k++;
			end while (v[2] !== 1'b1 && k < 3000);
			axiRd(EER_OFS_DATA, v, r);
			chk("data byte", e[i], v);
			chk("data rresp", EER_RESP_OKAY, r);
		end
		waitIdle(v);
		chk("status after read", 3'b000, v[2:0]);
	endtask : eeRead
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		logic [31:0] v;
		logic [1:0] r;
		chk("curAddr", 0, curAddr);
		chk("wpCfg", 0, wpCfg);
		axiRd(8'h10, v, r);
		chk("unmapped rresp", EER_RESP_SLVERR, r);
		chk("unmapped rdata", 0, v);
		axiWr(8'h10, 32'h1, r);
		chk("unmapped bresp", EER_RESP_SLVERR, r);
		eeRead(16'h000A, 1'b0, '{EER_ERASED});
		chk("curAddr", 11, curAddr);
	endtask : t_regs
	task automatic t_prot();
		logic [31:0] v;
		logic [1:0] r;
		wpPut(4'hB);
		wpPut(4'h0);
		chk("wpCfg", 4'hB, wpCfg);
		eeRead(16'hC0A3, 1'b0, '{8'h0B, 8'h0B, 8'h0B});
		chk("curAddr", 11, curAddr);
		axiRd(EER_OFS_CTRL, v, r);
		chk("ctrl readback", 32'h00000200, v);
		axiRd(EER_OFS_ADDR, v, r);
		chk("addr readback", 32'h0000C0A3, v);
	endtask : t_prot
	task automatic t_array();
		eeRead(16'h0003, 1'b0, '{pat(3)});
		chk("curAddr", 4, curAddr);
		eeRead(16'h0000, 1'b1, '{pat(4)});
		chk("curAddr", 5, curAddr);
		eeRead(16'h003E, 1'b0, '{pat(62), pat(63), pat(0), pat(1)});
		chk("curAddr", 2, curAddr);
	endtask : t_array
	task automatic t_busy();
		logic [31:0] v;
		logic [1:0] r;
		@(posedge linkClk);
		progBusy <= 1'b1;
		axiWr(EER_OFS_ADDR, 32'h8000, r);
		axiWr(EER_OFS_CTRL, 32'h1, r);
		waitIdle(v);
		chk("status while programming", 3'b010, v[2:0]);
		@(posedge linkClk);
		progBusy <= 1'b0;
		eeRead(16'h0000, 1'b1, '{pat(2)});
	endtask : t_busy
	initial begin
		repeat (3) @(posedge sys_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 300 && ready !== 1'b1; i++) @(posedge linkClk);
		chk("ready", 1, ready);
		t_regs();
		for (int i = 0; i < 64; i++) memPut(AW'(i), pat(i));
		t_prot();
		t_array();
		t_busy();
		end_of_test();
	end
	initial begin
		repeat (90000) @(posedge sys_clk);
		mismatches++;
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
